// ==== logic/sss_defines.svh ====
// Constants for the serial select and status block: selects, bit positions, resets, timing.
// Assumes inclusion by bare name from the engine, peripheral and host files of the block.
`ifndef SSS_DEFINES_SVH
`define SSS_DEFINES_SVH
`define SSS_SEL_STATUS 2'h0
`define SSS_SEL_DATA 2'h1
`define SSS_SEL_CTRL 2'h2
`define SSS_ST_DONE 7
`define SSS_ST_WRITE_COLLISION_FLAG 6
`define SSS_ST_OVR 5
`define SSS_ST_MODE_FAULT_FLAG 4
`define SSS_ST_SOD 2
`define SSS_ST_SSM 1
`define SSS_ST_SSI 0
`define SSS_CT_IRQ_EN 7
`define SSS_CT_SPE 6
`define SSS_CT_MSTR 4
`define SSS_CT_CLOCK_PHASE 2
`define SSS_CT_MASK 8'hD4
`define SSS_CSR_RST 8'h00
`define SSS_CTRL_RST 8'h00
`define SSS_BYTE_RST 8'h00
`define SSS_HALF_DIV 4
`define SSS_LAST_EDGE 4'hF
`define SSS_LAST_BIT 3'h7
`define SSS_SS_GAP 2'h3
`endif

// ==== logic/sss_pkg.sv ====
// Types shared by the serial select and status block.
// Assumes nothing beyond a SystemVerilog compiler.
package sss_pkg;
    // One-hot states of the master shift engine.
    typedef enum logic [2:0] {
        SSS_IDLE = 3'b001,
        SSS_RUN = 3'b010,
        SSS_FIN = 3'b100
    } sss_eng_state_t;
endpackage

// ==== logic/sss_link_if.sv ====
// Serial link between the peripheral end and the external master end.
// Assumes an idle-high pulled-up data-out line when nobody drives it.
`timescale 1ns/10ps
`default_nettype none
interface sss_link_if;
    logic host_sck;
    logic host_ss_n;
    logic host_mosi;
    logic dev_sck_o;
    logic dev_sck_oe;
    logic dev_mosi_o;
    logic dev_mosi_oe;
    logic dev_miso_o;
    logic dev_miso_oe;
    logic sck;
    logic mosi;
    logic miso;
    logic ss_n;
    // Resolve each shared wire from its drivers' enables.
    assign sck = dev_sck_oe ? dev_sck_o : host_sck;
    assign mosi = dev_mosi_oe ? dev_mosi_o : host_mosi;
    assign miso = dev_miso_oe ? dev_miso_o : 1'b1;
    assign ss_n = host_ss_n;
    modport dev_mp (input sck, mosi, miso, ss_n, output dev_sck_o, dev_sck_oe,
                    dev_mosi_o, dev_mosi_oe, dev_miso_o, dev_miso_oe);
    modport host_mp (input sck, miso, output host_sck, host_ss_n, host_mosi);
endinterface
`default_nettype wire

// ==== logic/sss_master_eng.sv ====
// Master byte shifter: divides its clock into a serial clock and exchanges one byte.
// Assumes the serial clock idles low and the far end follows the same clock phase.
`timescale 1ns/10ps
`default_nettype none
`include "sss_defines.svh"
module sss_master_eng #(
    parameter int HALF_DIV = `SSS_HALF_DIV
) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic clk_en_in,
    input wire logic start_in,
    input wire logic [7:0] tx_in,
    input wire logic clock_phase_in,
    input wire logic sdi_in,
    output logic sck_out,
    output logic sdo_out,
    output logic busy_out,
    output logic done_out,
    output logic [7:0] rx_out
);
    sss_pkg::sss_eng_state_t state_r;
    logic sdi_meta_r;
    logic sdi_r;
    logic [7:0] div_r;
    logic [3:0] edge_r;
    logic [7:0] shreg_r;
    logic smp_r;
    logic clock_phase_r;
    logic tick;

    assign tick = (div_r == 8'(HALF_DIV - 1));

    // Two-stage synchroniser for the incoming serial data pin.
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sdi_meta_r <= 1'b1;
            sdi_r <= 1'b1;
        end else if (clk_en_in) begin
            sdi_meta_r <= sdi_in;
            sdi_r <= sdi_meta_r;
        end
    end

    // Clock generation, sampling and shifting, most significant bit first.
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_r <= sss_pkg::SSS_IDLE;
            div_r <= 8'h00;
            edge_r <= 4'h0;
            shreg_r <= `SSS_BYTE_RST;
            smp_r <= 1'b0;
            clock_phase_r <= 1'b0;
            sck_out <= 1'b0;
            done_out <= 1'b0;
            busy_out <= 1'b0;
        end else if (clk_en_in) begin
            done_out <= 1'b0;
            case (state_r)
                sss_pkg::SSS_IDLE: begin
                    if (start_in) begin
                        shreg_r <= tx_in;
                        clock_phase_r <= clock_phase_in;
                        div_r <= 8'h00;
                        edge_r <= 4'h0;
                        busy_out <= 1'b1;
                        state_r <= sss_pkg::SSS_RUN;
                    end
                end
                sss_pkg::SSS_RUN: begin
                    div_r <= tick ? 8'h00 : div_r + 8'h01;
                    if (tick) begin
                        sck_out <= ~sck_out;
                        edge_r <= edge_r + 4'h1;
                        if (edge_r[0] == clock_phase_r) begin
                            smp_r <= sdi_r;
                        end else if (!(clock_phase_r && edge_r == 4'h0)) begin
                            shreg_r <= {shreg_r[6:0], smp_r};
                        end
                        if (edge_r == `SSS_LAST_EDGE) begin
                            state_r <= sss_pkg::SSS_FIN;
                        end
                    end
                end
                sss_pkg::SSS_FIN: begin
                    if (clock_phase_r) begin
                        shreg_r <= {shreg_r[6:0], smp_r};
                    end
                    done_out <= 1'b1;
                    busy_out <= 1'b0;
                    state_r <= sss_pkg::SSS_IDLE;
                end
                default: begin
                    state_r <= sss_pkg::SSS_IDLE;
                end
            endcase
        end
    end

    assign sdo_out = shreg_r[7];
    assign rx_out = shreg_r;
endmodule // sss_master_eng
`default_nettype wire

// ==== logic/sss_device.sv ====
// Peripheral end: select management, status flags, data port, master and slave shifting.
// Assumes a CPU register port on the system clock; slave shifting runs on the link clock.
`timescale 1ns/10ps
`default_nettype none
`include "sss_defines.svh"
module sss_device #(
    parameter int HALF_DIV = `SSS_HALF_DIV
) (
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    input wire logic clk_en_in,
    input wire logic [1:0] reg_sel_in,
    input wire logic reg_rd_in,
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    output logic irq_out,
    sss_link_if.dev_mp lnk
);
    logic transfer_done_flag_r, write_collision_flag_r, ovr_r, mode_fault_flag_r, sod_r, ssm_r, ssi_r;
    logic sts_seen_r, ctrl_seen_r, need_desel_r, done_prev_r;
    logic sck_oe_r, mosi_oe_r;
    logic [7:0] ctrl_r;
    logic [7:0] tx_byte_r;
    logic [7:0] rx_buf_r;
    logic [2:0] meta_r;
    logic [2:0] sync_r;
    logic [2:0] async_in;
    // Link-domain state.
    logic [2:0] scnt_r;
    logic [2:0] lcnt_r;
    logic [6:0] rx_sh_r;
    logic [7:0] rx_hold_r;
    logic done_tgl_r, mid_r;
    logic sck_smp, lrst_n, ss_int_raw;
    logic [2:0] bitpos;
    // System-domain decode.
    logic spi_enable, mstr, clock_phase, irq_en, ss_int_sys, busy;
    logic sts_acc, data_acc, ctrl_acc, wr_data, blocked, collide, accept;
    logic new_byte, slv_done, m_done, m_busy, m_sck, m_sdo;
    logic [7:0] new_data, m_rx;

    assign spi_enable = ctrl_r[`SSS_CT_SPE];
    assign mstr = ctrl_r[`SSS_CT_MSTR];
    assign clock_phase = ctrl_r[`SSS_CT_CLOCK_PHASE];
    assign irq_en = ctrl_r[`SSS_CT_IRQ_EN];

    // Internal select level: soft level or the external pin.
    assign ss_int_raw = ssm_r ? ssi_r : lnk.ss_n;
    assign ss_int_sys = ssm_r ? ssi_r : sync_r[0];

    // Link-domain logic, except the completed byte and its toggle, is held in reset while deselected, in master mode or disabled.
    assign lrst_n = arst_n_in & ~ss_int_raw & ~mstr & spi_enable;
    assign sck_smp = lnk.sck ^ clock_phase;

    // Slave sampling edge: shift in most significant bit first.
    always_ff @(posedge sck_smp or negedge lrst_n) begin
        if (!lrst_n) begin
            scnt_r <= 3'h0;
            rx_sh_r <= 7'h00;
            mid_r <= 1'b0;
        end else begin
            scnt_r <= scnt_r + 3'h1;
            rx_sh_r <= {rx_sh_r[5:0], lnk.mosi};
            mid_r <= (scnt_r != `SSS_LAST_BIT);
        end
    end

    // Completed slave byte and its toggle survive deselection.
    always_ff @(posedge sck_smp or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rx_hold_r <= `SSS_BYTE_RST;
            done_tgl_r <= 1'b0;
        end else if (lrst_n && scnt_r == `SSS_LAST_BIT) begin
            rx_hold_r <= {rx_sh_r, lnk.mosi};
            done_tgl_r <= ~done_tgl_r;
        end
    end

    // Slave launch edge: advance the outgoing bit position.
    always_ff @(negedge sck_smp or negedge lrst_n) begin
        if (!lrst_n) begin
            lcnt_r <= 3'h0;
        end else begin
            lcnt_r <= lcnt_r + 3'h1;
        end
    end

    // Second-edge mode shows its first bit on the first launch edge.
    assign bitpos = lcnt_r - {2'b00, clock_phase};
    assign lnk.dev_miso_o = tx_byte_r[3'h7 - bitpos];
    assign lnk.dev_miso_oe = spi_enable & ~mstr & ~sod_r & ~ss_int_raw;
    assign lnk.dev_sck_o = m_sck;
    assign lnk.dev_sck_oe = sck_oe_r;
    assign lnk.dev_mosi_o = m_sdo;
    assign lnk.dev_mosi_oe = mosi_oe_r;

    // Two-flop synchronisers for select pin, byte toggle and mid-byte level.
    assign async_in = {mid_r, done_tgl_r, lnk.ss_n};
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
                if (!arst_n_in) begin
                    meta_r[gi] <= (gi == 0);
                    sync_r[gi] <= (gi == 0);
                end else if (clk_en_in) begin
                    meta_r[gi] <= async_in[gi];
                    sync_r[gi] <= meta_r[gi];
                end
            end
        end
    endgenerate

    // Master engine started by an accepted data write.
    sss_master_eng #(.HALF_DIV(HALF_DIV)) u_eng (
        .clk_in(sys_clk_in),
        .arst_n_in(arst_n_in),
        .clk_en_in(clk_en_in),
        .start_in(accept & mstr & spi_enable),
        .tx_in(reg_wdata_in),
        .clock_phase_in(clock_phase),
        .sdi_in(lnk.miso),
        .sck_out(m_sck),
        .sdo_out(m_sdo),
        .busy_out(m_busy),
        .done_out(m_done),
        .rx_out(m_rx)
    );

    // Access decode and data-write qualification.
    assign sts_acc = clk_en_in & (reg_rd_in | reg_wr_in) & (reg_sel_in == `SSS_SEL_STATUS);
    assign data_acc = clk_en_in & (reg_rd_in | reg_wr_in) & (reg_sel_in == `SSS_SEL_DATA);
    assign ctrl_acc = clk_en_in & (reg_rd_in | reg_wr_in) & (reg_sel_in == `SSS_SEL_CTRL);
    assign wr_data = clk_en_in & reg_wr_in & (reg_sel_in == `SSS_SEL_DATA);
    assign blocked = transfer_done_flag_r & ~sts_seen_r;
    assign busy = mstr ? m_busy : sync_r[2];
    assign collide = busy | (~mstr & ~clock_phase & need_desel_r);
    assign accept = wr_data & ~blocked & ~collide;
    assign slv_done = sync_r[1] ^ done_prev_r;
    assign new_byte = clk_en_in & (mstr ? m_done : slv_done);
    assign new_data = mstr ? m_rx : rx_hold_r;

    // Status flags: a hardware set wins over a software clear.
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            transfer_done_flag_r <= 1'b0;
            write_collision_flag_r <= 1'b0;
            ovr_r <= 1'b0;
            mode_fault_flag_r <= 1'b0;
        end else begin
            transfer_done_flag_r <= new_byte | (transfer_done_flag_r & ~(data_acc & sts_seen_r));
            write_collision_flag_r <= (wr_data & ~blocked & collide) |
                      (write_collision_flag_r & ~(data_acc & sts_seen_r));
            ovr_r <= (new_byte & transfer_done_flag_r) |
                     (ovr_r & ~(sts_acc & reg_rd_in));
            mode_fault_flag_r <= (clk_en_in & mstr & spi_enable & ~ss_int_sys) |
                      (mode_fault_flag_r & ~(ctrl_seen_r & ctrl_acc & reg_wr_in));
        end
    end

    // Clearing-sequence arming and deselect tracking.
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sts_seen_r <= 1'b0;
            ctrl_seen_r <= 1'b0;
            need_desel_r <= 1'b0;
            done_prev_r <= 1'b0;
        end else if (clk_en_in) begin
            done_prev_r <= sync_r[1];
            // A fresh byte disarms the clear, so only a later status access counts.
            if (new_byte) begin
                sts_seen_r <= 1'b0;
            end else if (sts_acc) begin
                sts_seen_r <= 1'b1;
            end else if (data_acc) begin
                sts_seen_r <= 1'b0;
            end
            if (ctrl_acc && reg_wr_in) begin
                ctrl_seen_r <= 1'b0;
            end else if (ctrl_acc && mode_fault_flag_r) begin
                ctrl_seen_r <= 1'b1;
            end
            if (!mstr && !clock_phase && slv_done) begin
                need_desel_r <= 1'b1;
            end else if (ss_int_sys) begin
                need_desel_r <= 1'b0;
            end
        end
    end

    // Software-written control, status bits and transmit byte.
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ctrl_r <= `SSS_CTRL_RST;
            sod_r <= 1'b0;
            ssm_r <= 1'b0;
            ssi_r <= 1'b0;
            tx_byte_r <= `SSS_BYTE_RST;
        end else if (clk_en_in) begin
            if (ctrl_acc && reg_wr_in) begin
                ctrl_r <= reg_wdata_in & `SSS_CT_MASK;
            end
            if (sts_acc && reg_wr_in) begin
                sod_r <= reg_wdata_in[`SSS_ST_SOD];
                ssm_r <= reg_wdata_in[`SSS_ST_SSM];
                ssi_r <= reg_wdata_in[`SSS_ST_SSI];
            end
            if (accept) begin
                tx_byte_r <= reg_wdata_in;
            end
        end
    end

    // Receive buffer, read data, output enables and interrupt.
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rx_buf_r <= `SSS_BYTE_RST;
            reg_rdata_out <= 8'h00;
            irq_out <= 1'b0;
            sck_oe_r <= 1'b0;
            mosi_oe_r <= 1'b0;
        end else if (clk_en_in) begin
            if (new_byte && !transfer_done_flag_r) begin
                rx_buf_r <= new_data;
            end
            if (reg_rd_in) begin
                case (reg_sel_in)
                    `SSS_SEL_STATUS: reg_rdata_out <= {transfer_done_flag_r, write_collision_flag_r, ovr_r, mode_fault_flag_r,
                                                       1'b0, sod_r, ssm_r, ssi_r};
                    `SSS_SEL_DATA: reg_rdata_out <= rx_buf_r;
                    `SSS_SEL_CTRL: reg_rdata_out <= ctrl_r;
                    default: reg_rdata_out <= 8'h00;
                endcase
            end
            irq_out <= irq_en & (transfer_done_flag_r | ovr_r | mode_fault_flag_r);
            sck_oe_r <= spi_enable & mstr;
            mosi_oe_r <= spi_enable & mstr & ~sod_r;
        end
    end
endmodule // sss_device
`default_nettype wire

// ==== logic/sss_host.sv ====
// External master end: drives select, serial clock and data out, reads data in.
// Assumes the user waits for busy low before each start.
`timescale 1ns/10ps
`default_nettype none
`include "sss_defines.svh"
module sss_host #(
    parameter int HALF_DIV = `SSS_HALF_DIV
) (
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    input wire logic clk_en_in,
    input wire logic start_in,
    input wire logic [7:0] tx_byte_in,
    input wire logic clock_phase_in,
    input wire logic hold_select_in,
    input wire logic release_in,
    output logic busy_out,
    output logic done_out,
    output logic [7:0] rx_byte_out,
    sss_link_if.host_mp lnk
);
    logic ss_r;
    logic [1:0] gap_r;
    logic eng_busy, eng_done, go;
    logic [7:0] eng_rx;

    assign go = start_in & ~busy_out & clk_en_in;

    // Shared engine makes the serial clock and shifts the byte.
    sss_master_eng #(.HALF_DIV(HALF_DIV)) u_eng (
        .clk_in(sys_clk_in),
        .arst_n_in(arst_n_in),
        .clk_en_in(clk_en_in),
        .start_in(go),
        .tx_in(tx_byte_in),
        .clock_phase_in(clock_phase_in),
        .sdi_in(lnk.miso),
        .sck_out(lnk.host_sck),
        .sdo_out(lnk.host_mosi),
        .busy_out(eng_busy),
        .done_out(eng_done),
        .rx_out(eng_rx)
    );

    // Select low per byte; raised between bytes unless hold_select_in keeps it low, in either clock phase.
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ss_r <= 1'b1;
            gap_r <= 2'h0;
            busy_out <= 1'b0;
            done_out <= 1'b0;
            rx_byte_out <= `SSS_BYTE_RST;
        end else if (clk_en_in) begin
            done_out <= eng_done;
            if (gap_r != 2'h0) begin
                gap_r <= gap_r - 2'h1;
            end
            if (go) begin
                ss_r <= 1'b0;
            end else if (eng_done && !hold_select_in) begin
                ss_r <= 1'b1;
                gap_r <= `SSS_SS_GAP;
            end else if (release_in && !eng_busy) begin
                ss_r <= 1'b1;
                gap_r <= `SSS_SS_GAP;
            end
            if (eng_done) begin
                rx_byte_out <= eng_rx;
            end
            busy_out <= go | (eng_busy & ~eng_done) |
                        (eng_done & ~hold_select_in) | (gap_r > 2'h1);
        end
    end

    assign lnk.host_ss_n = ss_r;
endmodule // sss_host
`default_nettype wire

// ==== verification/sss_link_monitor.sv ====
// Checker on the serial link wires between the external master end and the peripheral.
// Assumes one system clock domain and the default half period of four clocks.
`timescale 1ns/10ps
`default_nettype none
module sss_link_monitor (
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    input wire logic host_sck,
    input wire logic host_ss_n,
    input wire logic dev_sck_o,
    input wire logic dev_sck_oe,
    input wire logic dev_miso_oe,
    input wire logic sck,
    input wire logic dev_mosi_oe
);
    logic [4:0] edge_cnt_r;
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!arst_n_in);
    // Counts serial clock rises inside one select frame, cleared while deselected.
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            edge_cnt_r <= 5'h00;
        end else if (host_ss_n) begin
            edge_cnt_r <= 5'h00;
        end else if ($rose(host_sck)) begin
            edge_cnt_r <= edge_cnt_r + 5'h01;
        end
    end
    // The master clock must rest outside frames and keep its half period.
    AST_SCK_IDLE: assert property (host_ss_n |-> !host_sck)
        else $error("serial clock moved outside a frame");
    AST_SCK_HALF: assert property ($changed(host_sck) |=> $stable(host_sck)[*3])
        else $error("master serial clock half period too short");
    AST_DEV_HALF: assert property (dev_sck_oe && $changed(dev_sck_o) |=> $stable(dev_sck_o)[*3])
        else $error("peripheral serial clock half period too short");
    AST_FRAME_BYTES: assert property ($rose(host_ss_n) |-> edge_cnt_r[2:0] == 3'h0)
        else $error("frame closed with a partial byte");
    AST_ONE_MASTER: assert property (dev_miso_oe |-> !dev_sck_oe)
        else $error("peripheral drives clock and slave output together");
    AST_LINE_REST: assert property (!dev_sck_oe && host_ss_n |-> !sck)
        else $error("resolved serial clock not idle low");
    AST_FIRST_EDGE: assert property ($fell(host_ss_n) |-> ##[1:12] $rose(host_sck))
        else $error("no serial clock after select fell");
    AST_DESEL_GAP: assert property ($rose(host_ss_n) |-> host_ss_n[*3])
        else $error("select not held high between bytes");
    AST_MOSI_ROLE: assert property (dev_mosi_oe |-> dev_sck_oe)
        else $error("peripheral drives master output outside master mode");
    AST_DEV_START: assert property ($rose(dev_sck_oe) |-> !dev_sck_o)
        else $error("peripheral clock did not start from idle low");
endmodule // sss_link_monitor
`default_nettype wire

// ==== verification/spi_select_and_status_tb.sv ====
// Self-checking bench: both ends joined by the link, register port driven by tasks.
// Assumes the default half period of four system clocks on both ends.
`timescale 1ns/10ps
`default_nettype none
module spi_select_and_status_tb;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [1:0] sel = 2'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic irq;
    logic start = 1'b0;
    logic [7:0] tx = 8'h00;
    logic clock_phase = 1'b0;
    logic hold = 1'b0;
    logic rel = 1'b0;
    logic busy;
    logic done;
    logic [7:0] rx;
    logic [7:0] cap = 8'h00;
    logic [7:0] tmp;
    int n_fail = 0;
    int check_count = 0;
    int cyc = 0;
    sss_link_if lnk_if ();
    sss_device sss_device_inst (
        .sys_clk_in(sys_clk), .arst_n_in(arst_n), .clk_en_in(1'b1), .reg_sel_in(sel),
        .reg_rd_in(rd), .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
        .irq_out(irq), .lnk(lnk_if.dev_mp)
    );
    sss_host sss_host_inst (
        .sys_clk_in(sys_clk), .arst_n_in(arst_n), .clk_en_in(1'b1), .start_in(start),
        .tx_byte_in(tx), .clock_phase_in(clock_phase), .hold_select_in(hold), .release_in(rel),
        .busy_out(busy), .done_out(done), .rx_byte_out(rx), .lnk(lnk_if.host_mp)
    );
    sss_link_monitor sss_link_monitor_inst (
        .sys_clk_in(sys_clk), .arst_n_in(arst_n), .host_sck(lnk_if.host_sck),
        .host_ss_n(lnk_if.host_ss_n), .dev_sck_o(lnk_if.dev_sck_o),
        .dev_sck_oe(lnk_if.dev_sck_oe), .dev_miso_oe(lnk_if.dev_miso_oe),
        .sck(lnk_if.sck), .dev_mosi_oe(lnk_if.dev_mosi_oe)
    );
    // System clock of 40 ns.
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    // Collects the master-out line on every rising serial clock edge.
    always @(posedge lnk_if.sck) begin
        cap <= {cap[6:0], lnk_if.mosi};
    end
    // Cuts a hung run short.
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            n_fail++;
            test_done();
        end
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", name, exp, got);
            n_fail++;
        end
    endtask
    task automatic reg_wr(input logic [1:0] s, input logic [7:0] d);
        @(posedge sys_clk);
        sel <= s;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [1:0] s);
        @(posedge sys_clk);
        sel <= s;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1 tmp = rdata;
    endtask
    task automatic rd_chk(input logic [1:0] s, input logic [7:0] exp, input string name);
        reg_rd(s);
        chk(name, exp, tmp);
    endtask
    task automatic host_go(input logic [7:0] t, input logic c, input logic h);
        @(posedge sys_clk);
        start <= 1'b1;
        tx <= t;
        clock_phase <= c;
        hold <= h;
        @(posedge sys_clk);
        start <= 1'b0;
    endtask
    // Waits for the end of the byte, then lets the peripheral flags settle.
    task automatic host_wait();
        int i;
        for (i = 0; i < 300 && done !== 1'b1; i++) begin
            @(posedge sys_clk);
            #1;
        end
        repeat (8) @(posedge sys_clk);
    endtask
    task automatic release_sel();
        @(posedge sys_clk);
        rel <= 1'b1;
        @(posedge sys_clk);
        rel <= 1'b0;
    endtask
    // Main sequence of register accesses and link transfers.
    initial begin
        repeat (6) @(posedge sys_clk);
        arst_n <= 1'b1;
        rd_chk(2'h0, 8'h00, "status reset");
        rd_chk(2'h2, 8'h00, "control reset");
        rd_chk(2'h3, 8'h00, "unmapped");
        // Slave, first-edge phase, interrupt enabled.
        reg_wr(2'h2, 8'hC0);
        reg_wr(2'h1, 8'hA5);
        host_go(8'h3C, 1'b0, 1'b0);
        host_wait();
        chk("host rx", 8'hA5, rx);
        chk("host idle", 8'h00, {7'h00, busy});
        chk("irq set", 8'h01, {7'h00, irq});
        rd_chk(2'h0, 8'h80, "status done");
        rd_chk(2'h1, 8'h3C, "data rx");
        rd_chk(2'h0, 8'h00, "status cleared");
        chk("irq clear", 8'h00, {7'h00, irq});
        // Write while done is pending, then a byte arriving on top of it.
        host_go(8'h11, 1'b0, 1'b0);
        host_wait();
        reg_wr(2'h1, 8'h77);
        host_go(8'h22, 1'b0, 1'b0);
        host_wait();
        rd_chk(2'h0, 8'hA0, "status overrun");
        rd_chk(2'h1, 8'h11, "data kept");
        rd_chk(2'h0, 8'h00, "status cleared");
        // Select kept low after a first-edge byte, then a slave write.
        host_go(8'h33, 1'b0, 1'b1);
        host_wait();
        rd_chk(2'h0, 8'h80, "status done");
        rd_chk(2'h1, 8'h33, "data rx");
        reg_wr(2'h1, 8'h44);
        rd_chk(2'h0, 8'h40, "status collision");
        rd_chk(2'h1, 8'h33, "data kept");
        rd_chk(2'h0, 8'h00, "status cleared");
        release_sel();
        // Second-edge phase with a data write in mid byte.
        reg_wr(2'h2, 8'hC4);
        host_go(8'h55, 1'b1, 1'b0);
        repeat (20) @(posedge sys_clk);
        chk("host busy", 8'h01, {7'h00, busy});
        reg_wr(2'h1, 8'h66);
        host_wait();
        rd_chk(2'h0, 8'hC0, "status collision");
        rd_chk(2'h1, 8'h55, "data rx");
        rd_chk(2'h0, 8'h00, "status cleared");
        // Software select at the deselect level ignores the pin.
        reg_wr(2'h2, 8'hC0);
        reg_wr(2'h0, 8'h03);
        rd_chk(2'h0, 8'h03, "status soft");
        host_go(8'h12, 1'b0, 1'b0);
        host_wait();
        chk("host rx deselected", 8'hFF, rx);
        rd_chk(2'h0, 8'h03, "status no done");
        // Output disable keeps the slave output off the line.
        reg_wr(2'h0, 8'h04);
        reg_wr(2'h1, 8'h00);
        host_go(8'h13, 1'b0, 1'b0);
        host_wait();
        chk("host rx disabled", 8'hFF, rx);
        rd_chk(2'h0, 8'h84, "status done");
        rd_chk(2'h1, 8'h13, "data rx");
        rd_chk(2'h0, 8'h04, "status cleared");
        reg_wr(2'h0, 8'h00);
        // Master mode; the external end keeps select high meanwhile.
        reg_wr(2'h2, 8'hD0);
        reg_wr(2'h1, 8'hC3);
        repeat (90) @(posedge sys_clk);
        chk("mosi byte", 8'hC3, cap);
        rd_chk(2'h0, 8'h80, "status done");
        rd_chk(2'h1, 8'hFF, "data rx");
        host_go(8'h00, 1'b0, 1'b0);
        host_wait();
        rd_chk(2'h0, 8'h10, "status fault");
        chk("irq fault", 8'h01, {7'h00, irq});
        reg_rd(2'h2);
        reg_wr(2'h2, 8'hD0);
        rd_chk(2'h0, 8'h00, "status fault cleared");
        test_done();
    end
endmodule // spi_select_and_status_tb
`default_nettype wire
